// ---- psfc_defines.svh ----
`ifndef PSFC_DEFINES_SVH
`define PSFC_DEFINES_SVH

`define PSFC_OFS_PIN_LOW 8'h1C
`define PSFC_OFS_PIN_HIGH 8'h1D
`define PSFC_OFS_PORT_SEL 8'h1E
`define PSFC_OFS_FREQ_CNT 8'h1F

`define PSFC_SEL_SECOND_EN 2
`define PSFC_SEL_PORT_ONE 1
`define PSFC_SEL_PORT_ZERO 0
`define PSFC_SEL_RESET 3'h1
`define PSFC_SEL_WIDTH 3

`define PSFC_PIN_REMOTE_LSB 0
`define PSFC_PIN_REMOTE_MSB 3
`define PSFC_PIN_RESERVED 4
`define PSFC_COUNT_MAX 8'hFF

`define PSFC_CLK_PERIOD_NS 25
`define PSFC_OSC_PERIOD_NS 40
`define PSFC_ACC_STEP 7'(`PSFC_CLK_PERIOD_NS)
`define PSFC_ACC_WRAP 7'(`PSFC_OSC_PERIOD_NS)

`endif

// ---- psfc_pkg.sv ----
package psfc_pkg;

  typedef enum logic [1:0]
  {
    PSFC_IDLE = 2'b01,
    PSFC_RUN = 2'b10
  } psfc_state_t;

  typedef struct packed
  {
    psfc_state_t state;
    logic [2:0] port_sel;
    logic [7:0] interval_left;
    logic [7:0] edge_count;
    logic pix_last;
    logic [6:0] osc_acc;
    logic [7:0] rdata;
    logic rvalid;
  } psfc_regs_t;

endpackage : psfc_pkg

// ---- psfc_top.sv ----
`timescale 1ns/10ps
`include "psfc_defines.svh"
// Summary of operation
// - 0x1C bits 7..5 show general pins 7..5
// - 0x1C bits 3..0 show pins, remote if port1
// - 0x1D bit 0 shows pin 8, rest zero
// - second enable adds address own plus one
// - second address reaches port 1 and shared
// - port 1 select writes/reads port 1 and shared
// - port 0 select writes port 0; port 1 reads win
// - selects ignored while second address enabled
// - 0x1F write counts pixel edges over interval
// - read 0x1F returns interval edge count, running while busy
// - edge count saturates at 0xFF
module psfc_top
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [6:0] OWN_BUS_ADDRESS,
  input wire logic [6:0] BUS_DEV_ADDR,
  input wire logic [7:0] BUS_REG_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [7:0] BUS_WDATA,
  output logic BUS_ACK,
  output logic [7:0] BUS_RDATA,
  output logic BUS_RVALID,
  output logic WRITE_PORT_ZERO,
  output logic WRITE_PORT_ONE,
  output logic WRITE_SHARED,
  output logic READ_PORT_ONE,
  input wire logic [8:0] GENERAL_PIN,
  input wire logic [3:0] REMOTE_PIN,
  input wire logic PIXEL_CLK,
  output logic COUNT_BUSY
);

  psfc_pkg::psfc_regs_t st_r;
  psfc_pkg::psfc_regs_t st_nxt;

  logic hit_primary;
  logic hit_second;
  logic sec_en;
  logic rd_port_one;
  logic osc_tick;
  logic pix_edge;
  logic [6:0] acc_sum;
  logic [7:0] rd_word;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == `PSFC_COUNT_MAX) ? v : v + 8'h01;
  endfunction : sat_inc

  assign sec_en = st_r.port_sel[`PSFC_SEL_SECOND_EN];
  assign hit_primary = (BUS_DEV_ADDR == OWN_BUS_ADDRESS);
  // address plus one wraps in 7 bits, as the bus field does
  assign hit_second = sec_en &&
    (BUS_DEV_ADDR == OWN_BUS_ADDRESS + 7'h01);
  assign BUS_ACK = hit_primary || hit_second;

  always_comb
  begin
    WRITE_PORT_ZERO = 1'b0;
    WRITE_PORT_ONE = 1'b0;
    rd_port_one = 1'b0;
    if (hit_second)
    begin
      WRITE_PORT_ONE = BUS_WR;
      rd_port_one = 1'b1;
    end
    else if (hit_primary && sec_en)
    begin
      // selection bits ignored: primary address means port 0
      WRITE_PORT_ZERO = BUS_WR;
    end
    else if (hit_primary)
    begin
      WRITE_PORT_ZERO = BUS_WR &&
        st_r.port_sel[`PSFC_SEL_PORT_ZERO];
      WRITE_PORT_ONE = BUS_WR &&
        st_r.port_sel[`PSFC_SEL_PORT_ONE];
      rd_port_one = st_r.port_sel[`PSFC_SEL_PORT_ONE];
    end
  end

  assign WRITE_SHARED = BUS_WR && BUS_ACK;
  assign READ_PORT_ONE = rd_port_one;
  assign BUS_RDATA = st_r.rdata;
  assign BUS_RVALID = st_r.rvalid;
  assign COUNT_BUSY = (st_r.state == psfc_pkg::PSFC_RUN);

  always_comb
  begin
    rd_word = 8'h00;
    case (BUS_REG_ADDR)
      `PSFC_OFS_PIN_LOW:
      begin
        rd_word = {GENERAL_PIN[7:5], 1'b0, GENERAL_PIN[3:0]};
        if (rd_port_one)
        begin
          rd_word[3:0] = REMOTE_PIN;
        end
      end
      `PSFC_OFS_PIN_HIGH: rd_word = {7'h00, GENERAL_PIN[8]};
      `PSFC_OFS_PORT_SEL: rd_word = {5'h00, st_r.port_sel};
      `PSFC_OFS_FREQ_CNT: rd_word = st_r.edge_count;
      default: rd_word = 8'h00;
    endcase
  end

  // oscillator period is not a whole number of ref cycles, so a
  // phase accumulator spaces ticks 40 ns apart on average
  assign acc_sum = st_r.osc_acc + `PSFC_ACC_STEP;
  assign osc_tick = (acc_sum >= `PSFC_ACC_WRAP);
  // both edges counted, so the saturated count can be reached; a
  // free-running pixel clock must stay below half the ref rate
  assign pix_edge = PIXEL_CLK != st_r.pix_last;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pix_last = PIXEL_CLK;
    st_nxt.rvalid = 1'b0;
    st_nxt.osc_acc = osc_tick ? acc_sum - `PSFC_ACC_WRAP : acc_sum;
    if (BUS_RD && BUS_ACK)
    begin
      st_nxt.rdata = rd_word;
      st_nxt.rvalid = 1'b1;
    end
    case (st_r.state)
      psfc_pkg::PSFC_IDLE: st_nxt.state = psfc_pkg::PSFC_IDLE;
      psfc_pkg::PSFC_RUN:
      begin
        if (pix_edge)
        begin
          st_nxt.edge_count = sat_inc(st_r.edge_count);
        end
        if (osc_tick)
        begin
          st_nxt.interval_left = st_r.interval_left - 8'h01;
          if (st_r.interval_left == 8'h01)
          begin
            st_nxt.state = psfc_pkg::PSFC_IDLE;
          end
        end
      end
      default: st_nxt.state = psfc_pkg::PSFC_IDLE;
    endcase
    if (WRITE_SHARED)
    begin
      if (BUS_REG_ADDR == `PSFC_OFS_PORT_SEL)
      begin
        st_nxt.port_sel = BUS_WDATA[2:0];
      end
      if (BUS_REG_ADDR == `PSFC_OFS_FREQ_CNT)
      begin
        // restart wins over any count in progress
        st_nxt.edge_count = 8'h00;
        st_nxt.interval_left = BUS_WDATA;
        st_nxt.osc_acc = 7'h00;
        st_nxt.state = (BUS_WDATA == 8'h00) ?
          psfc_pkg::PSFC_IDLE : psfc_pkg::PSFC_RUN;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st_r.state <= psfc_pkg::PSFC_IDLE;
      st_r.port_sel <= `PSFC_SEL_RESET;
      st_r.interval_left <= 8'h00;
      st_r.edge_count <= 8'h00;
      st_r.pix_last <= 1'b0;
      st_r.osc_acc <= 7'h00;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  a_pin_low_bits: assert property (
    BUS_RD && hit_primary && !sec_en && BUS_REG_ADDR == `PSFC_OFS_PIN_LOW
    |=> BUS_RVALID && BUS_RDATA[7:5] == $past(GENERAL_PIN[7:5])
        && !BUS_RDATA[4])
    else $error("pin status bits 7..5 wrong");

  a_remote_pins: assert property (
    BUS_RD && hit_second && BUS_REG_ADDR == `PSFC_OFS_PIN_LOW
    |=> BUS_RDATA[3:0] == $past(REMOTE_PIN))
    else $error("remote pin status not returned");

  a_pin_high_reg: assert property (
    BUS_RD && BUS_ACK && BUS_REG_ADDR == `PSFC_OFS_PIN_HIGH
    |=> BUS_RDATA == {7'h00, $past(GENERAL_PIN[8])})
    else $error("pin 8 status wrong");

  a_second_addr: assert property (
    BUS_DEV_ADDR == OWN_BUS_ADDRESS + 7'h01
    && BUS_DEV_ADDR != OWN_BUS_ADDRESS |-> BUS_ACK == sec_en)
    else $error("second address answer wrong");

  a_second_port: assert property (
    BUS_WR && hit_second |-> WRITE_PORT_ONE && !WRITE_PORT_ZERO
    && WRITE_SHARED)
    else $error("second address must reach port 1");

  a_select_route: assert property (
    BUS_WR && hit_primary && !hit_second && !sec_en |->
    WRITE_PORT_ONE == st_r.port_sel[1] && WRITE_PORT_ZERO == st_r.port_sel[0])
    else $error("port select routing wrong");

  a_select_ignored: assert property (
    hit_primary && !hit_second && sec_en |-> !READ_PORT_ONE
    && !WRITE_PORT_ONE)
    else $error("selects not ignored");

  a_count_saturate: assert property (
    st_r.edge_count == `PSFC_COUNT_MAX && !WRITE_SHARED
    |=> st_r.edge_count == `PSFC_COUNT_MAX)
    else $error("edge count wrapped");

  a_restart_clear: assert property (
    WRITE_SHARED && BUS_REG_ADDR == `PSFC_OFS_FREQ_CNT
    |=> st_r.edge_count == 8'h00
        && st_r.interval_left == $past(BUS_WDATA))
    else $error("counter write did not restart");

  a_interval_length: assert property (
    WRITE_SHARED && BUS_REG_ADDR == `PSFC_OFS_FREQ_CNT
    && BUS_WDATA == 8'h02 ##1 !WRITE_SHARED [*5]
    |-> !COUNT_BUSY)
    else $error("two tick interval too long");

endmodule : psfc_top

// ---- psfc_host.sv ----
`timescale 1ns/10ps
module psfc_host
(
  input wire logic clk,
  output logic [6:0] dev,
  output logic [7:0] ra,
  output logic wr,
  output logic rd,
  output logic [7:0] wd
);
  initial {dev, ra, wr, rd, wd} = '0;
  // one-cycle strobe; data inverted after so stale values never match
  task automatic acc(input logic w, input logic [6:0] d,
    input logic [7:0] a, input logic [7:0] v);
    dev <= d;
    ra <= a;
    wd <= v;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    wd <= ~v;
    // one idle edge, so a following call never re-drives a strobe
    @(posedge clk);
  endtask : acc
endmodule : psfc_host

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [6:0] own = 7'h2C;
  logic [6:0] dev;
  logic [7:0] ra, wd, rdat;
  logic wr, rd, ack, rv, wp0, wp1, ws, rp1, busy;
  logic pix = 1'b0;
  logic fast = 1'b0;
  logic [1:0] pc = '0;
  logic [8:0] gp = '0;
  logic [3:0] rp = '0;
  logic [8:0] q[$];
  logic [8:0] note;
  logic [2:0] p;
  int error_cnt = 0;
  int checks = 0;
  int n;
  initial forever #12.5 REF_CLK = ~REF_CLK;
  // quarter-rate pixel clock; fast mode toggles every cycle, in step
  // with the ref clock, so that the count can saturate
  always @(posedge REF_CLK)
  begin
    pc <= pc + 2'h1;
    pix <= fast ? ~pix : pc[1];
  end
  psfc_host h (.clk(REF_CLK), .dev(dev), .ra(ra), .wr(wr), .rd(rd),
    .wd(wd));
  psfc_top dut (.REF_CLK(REF_CLK), .RESET(RESET),
    .OWN_BUS_ADDRESS(own), .BUS_DEV_ADDR(dev), .BUS_REG_ADDR(ra),
    .BUS_WR(wr), .BUS_RD(rd), .BUS_WDATA(wd), .BUS_ACK(ack),
    .BUS_RDATA(rdat), .BUS_RVALID(rv), .WRITE_PORT_ZERO(wp0),
    .WRITE_PORT_ONE(wp1), .WRITE_SHARED(ws), .READ_PORT_ONE(rp1),
    .GENERAL_PIN(gp), .REMOTE_PIN(rp), .PIXEL_CLK(pix),
    .COUNT_BUSY(busy));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic tally(input logic [7:0] g, e, input logic t);
    checks++;
    if (g !== e && !(t && (g === e + 8'h01 || g === e - 8'h01)))
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : tally
  // read data; slack of one where the interval phase matters
  task automatic cmp_read(input logic [7:0] g, e, input logic t);
    tally(g, e, t);
  endtask : cmp_read
  // write strobes: shared, port one, port zero
  task automatic cmp_route(input logic [2:0] g, e);
    tally({5'h00, g}, {5'h00, e}, 1'b0);
  endtask : cmp_route
  task automatic cmp_level(input logic [7:0] g, e, input logic t);
    tally(g, e, t);
  endtask : cmp_level
  task automatic wrt(input logic [6:0] d, input logic [7:0] a, v,
    input logic [1:0] e);
    fork
      h.acc(1'b1, d, a, v);
      begin
        #1;
        cmp_route({ws, wp1, wp0}, {1'b1, e});
      end
    join
  endtask : wrt
  task automatic rdt(input logic [6:0] d, input logic [7:0] a, e,
    input logic t);
    q.push_back({t, e});
    h.acc(1'b0, d, a, 8'h00);
  endtask : rdt
  task automatic wait_idle(output int c);
    c = 0;
    // busy is looked at mid-cycle, where it has settled
    @(negedge REF_CLK);
    while (busy !== 1'b0)
    begin
      @(negedge REF_CLK);
      c++;
      if (c > 2000)
      begin
        error_cnt++;
        close_out();
      end
    end
    @(posedge REF_CLK);
  endtask : wait_idle
  always @(negedge REF_CLK)
    if (rv === 1'b1)
    begin
      if (q.size() == 0)
        cmp_level({7'h00, rv}, 8'h00, 1'b0);
      else
      begin
        note = q.pop_front();
        cmp_read(rdat, note[7:0], note[8]);
      end
    end
  initial
  begin
    void'($urandom(63357));
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    gp <= 9'($urandom);
    rp <= 4'($urandom);
    @(posedge REF_CLK);
    rdt(own, 8'h1E, 8'h01, 1'b0);
    rdt(own, 8'h1D, {7'h00, gp[8]}, 1'b0);
    wrt(own, 8'h1C, 8'hFF, 2'b01);
    rdt(own, 8'h1C, {gp[7:5], 1'b0, gp[3:0]}, 1'b0);
    rdt(own, 8'h1F, 8'h00, 1'b0);
    rdt(own, 8'h40, 8'h00, 1'b0);
    h.acc(1'b0, own + 7'h01, 8'h1E, 8'h00);
    cmp_level({7'h00, ack}, 8'h00, 1'b0);
    $display("test pins done");
    p = 3'h1;
    for (int s = 0; s < 8; s++)
    begin
      wrt(own, 8'h1E, 8'(s), p[2] ? 2'b01 : p[1:0]);
      p = 3'(s);
      @(posedge REF_CLK);
      cmp_level({7'h00, rp1}, {7'h00, !p[2] && p[1]}, 1'b0);
      rdt(own, 8'h1E, 8'(s), 1'b0);
      rdt(own, 8'h1C, {gp[7:5], 1'b0, (!p[2] && p[1]) ? rp : gp[3:0]},
        1'b0);
      if (p[2])
      begin
        wrt(own + 7'h01, 8'h40, 8'h00, 2'b10);
        rdt(own + 7'h01, 8'h1C, {gp[7:5], 1'b0, rp}, 1'b0);
      end
    end
    wrt(own, 8'h1E, 8'h01, 2'b01);
    rdt(own, 8'h1C, {gp[7:5], 1'b0, gp[3:0]}, 1'b0);
    $display("test ports done");
    // busy counts exclude the cycle the host spends before returning
    wrt(own, 8'h1F, 8'h02, 2'b01);
    wait_idle(n);
    cmp_level(8'(n), 8'h03, 1'b1);
    rdt(own, 8'h1F, 8'h02, 1'b1);
    wrt(own, 8'h1F, 8'hFF, 2'b01);
    repeat (3) @(posedge REF_CLK);
    wrt(own, 8'h1F, 8'h0A, 2'b01);
    wait_idle(n);
    cmp_level(8'(n), 8'h0F, 1'b1);
    rdt(own, 8'h1F, 8'h08, 1'b1);
    fast <= 1'b1;
    wrt(own, 8'h1F, 8'hFF, 2'b01);
    wait_idle(n);
    rdt(own, 8'h1F, 8'hFF, 1'b0);
    fast <= 1'b0;
    wrt(own, 8'h1F, 8'h00, 2'b01);
    repeat (2) @(posedge REF_CLK);
    cmp_level({7'h00, busy}, 8'h00, 1'b0);
    rdt(own, 8'h1F, 8'h00, 1'b0);
    repeat (2) @(posedge REF_CLK);
    cmp_level(8'(q.size()), 8'h00, 1'b0);
    $display("test counter done");
    close_out();
  end
endmodule : tb
